// file: logic/tcsi_bank.sv
// Purpose: Control registers, latched status bank and interrupt output
// Assumes: Port strobes are one-cycle pulses synchronous to ref_clk
// Notes:   Read data is registered and appears one cycle after cpu_rd
`default_nettype none
`timescale 1ns/1ps

// What this block does
// - Tx and rx CRC6 variant select bits, chosen independently per direction.
// - Line all-ones force replaces transmit line data with unframed all ones.
// - Five-bit transmit channel field picks channel copied to transmit monitor.
// - Five-bit receive channel field picks channel copied to receive monitor.
// - Rising edge of line interface reset bit fires one internal reset.
// - Remote loop sends received line data back out, formatter ignored.
// - Status bit sets on its event or alarm and holds until read.
// - Read clears latched bit where mask and image bits are one; alarm bits stay set while alarm persists.
// - Mask write refreshes read image only where mask bit is one.
// - Status one, two and link status drive interrupt through masks.
// - Unmasked alarm bit asserts interrupt on every alarm state change.
// - Reading the alarm bit releases interrupt even with alarm active.
// - Unmasked event bit asserts interrupt; reading it releases it.
// - Rising edge of elastic store reset bit forces known store depth.
module tcsi_bank (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Parallel control port
  input  wire logic [7:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  output logic            int_b,
  // Status sources, events are pulses, alarms are levels
  input  wire logic [7:0] status_one_event,
  input  wire logic [3:0] status_one_alarm,
  input  wire logic [7:0] status_two_event,
  input  wire logic [7:0] rx_info_one_event,
  input  wire logic [7:0] rx_info_two_event,
  input  wire logic [7:0] rx_info_three_event,
  input  wire logic [7:0] link_status_event,
  // Channel data for monitors
  input  wire logic       tx_chan_stb,
  input  wire logic [4:0] tx_chan_num,
  input  wire logic [7:0] tx_chan_data,
  input  wire logic       rx_chan_stb,
  input  wire logic [4:0] rx_chan_num,
  input  wire logic [7:0] rx_chan_data,
  // Line data, one bit per tx_bit_stb
  input  wire logic       tx_bit_stb,
  input  wire logic       fmt_tx_pos,
  input  wire logic       fmt_tx_neg,
  input  wire logic       line_rx_positive_in,
  input  wire logic       line_rx_negative_in,
  output logic            line_tx_positive_out,
  output logic            line_tx_negative_out,
  // Controls toward framer and line interface
  output logic            tx_crc_variant_sel,
  output logic            rx_crc_variant_sel,
  output logic            line_if_reset_pulse,
  output logic            elastic_store_reset_pulse
);

  // Control registers
  logic [7:0] ccr_tx_q, ccr_tx_d;
  logic [7:0] ccr_rx_q, ccr_rx_d;
  logic [7:0] ccr_rl_q, ccr_rl_d;
  logic [7:0] ccr_es_q, ccr_es_d;
  logic [7:0] irq_mask_one_q,   irq_mask_one_d;
  logic [7:0] irq_mask_two_q,   irq_mask_two_d;
  logic [7:0] link_channel_irq_mask_q,   link_channel_irq_mask_d;
  logic [7:0] tmon_q,   tmon_d;
  logic [7:0] rmon_q,   rmon_d;

  // Status bank
  logic [7:0] evt      [tcsi_pkg::NUM_STATUS];
  logic [7:0] lat_q    [tcsi_pkg::NUM_STATUS];
  logic [7:0] img_q    [tcsi_pkg::NUM_STATUS];
  logic [7:0] msk_q    [tcsi_pkg::NUM_STATUS];
  logic [tcsi_pkg::NUM_STATUS-1:0] wr_hit;
  logic [tcsi_pkg::NUM_STATUS-1:0] rd_hit;
  logic [3:0] alm_prev_q, alm_prev_d;
  logic [3:0] chg_q,      chg_d;

  // Outputs and edge state
  logic [7:0] rdata_q, rdata_d;
  logic       int_b_q, int_b_d;
  logic       ltx_p_q, ltx_p_d;
  logic       ltx_n_q, ltx_n_d;
  logic       ais_mark_q, ais_mark_d;
  logic       lir_pulse_q, lir_pulse_d;
  logic       es_pulse_q,  es_pulse_d;
  logic       pend;

  assign evt[tcsi_pkg::IDX_SR1]  = status_one_event
                                 | {4'h0, status_one_alarm};
  assign evt[tcsi_pkg::IDX_SR2]  = status_two_event;
  assign evt[tcsi_pkg::IDX_RX_INFO_REG_ONE] = rx_info_one_event;
  assign evt[tcsi_pkg::IDX_RX_INFO_REG_TWO] = rx_info_two_event;
  assign evt[tcsi_pkg::IDX_RX_INFO_REG_THREE] = rx_info_three_event
                                 & tcsi_pkg::RX_INFO_THREE_USED;
  assign evt[tcsi_pkg::IDX_LINK_CHANNEL_STATUS] = link_status_event;

  // Status address decode
  always_comb
  begin
    wr_hit = '0;
    rd_hit = '0;
    if (cpu_addr == tcsi_pkg::OFS_STATUS_ONE)
    begin
      wr_hit[tcsi_pkg::IDX_SR1] = cpu_wr;
      rd_hit[tcsi_pkg::IDX_SR1] = cpu_rd;
    end
    else if (cpu_addr == tcsi_pkg::OFS_STATUS_TWO)
    begin
      wr_hit[tcsi_pkg::IDX_SR2] = cpu_wr;
      rd_hit[tcsi_pkg::IDX_SR2] = cpu_rd;
    end
    else if (cpu_addr == tcsi_pkg::OFS_RX_INFO_ONE)
    begin
      wr_hit[tcsi_pkg::IDX_RX_INFO_REG_ONE] = cpu_wr;
      rd_hit[tcsi_pkg::IDX_RX_INFO_REG_ONE] = cpu_rd;
    end
    else if (cpu_addr == tcsi_pkg::OFS_RX_INFO_TWO)
    begin
      wr_hit[tcsi_pkg::IDX_RX_INFO_REG_TWO] = cpu_wr;
      rd_hit[tcsi_pkg::IDX_RX_INFO_REG_TWO] = cpu_rd;
    end
    else if (cpu_addr == tcsi_pkg::OFS_RX_INFO_THREE)
    begin
      wr_hit[tcsi_pkg::IDX_RX_INFO_REG_THREE] = cpu_wr;
      rd_hit[tcsi_pkg::IDX_RX_INFO_REG_THREE] = cpu_rd;
    end
    else if (cpu_addr == tcsi_pkg::OFS_LINK_STATUS)
    begin
      wr_hit[tcsi_pkg::IDX_LINK_CHANNEL_STATUS] = cpu_wr;
      rd_hit[tcsi_pkg::IDX_LINK_CHANNEL_STATUS] = cpu_rd;
    end
  end

  // One latch, read image and mask per status register
  for (genvar g = 0; g < tcsi_pkg::NUM_STATUS; g++)
  begin : g_status
    logic [7:0] lat_d, img_d, msk_d;

    always_comb
    begin
      lat_d = lat_q[g];
      img_d = img_q[g];
      msk_d = msk_q[g];
      if (wr_hit[g])
      begin
        // Only selected positions take fresh status
        img_d = (img_q[g] & ~cpu_wdata) | (lat_q[g] & cpu_wdata);
        msk_d = cpu_wdata;
      end
      if (rd_hit[g])
        lat_d = lat_q[g] & ~(msk_q[g] & img_q[g]);
      // Set beats clear so a coincident event is not lost
      lat_d = lat_d | evt[g];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        lat_q[g] <= tcsi_pkg::RESET_BYTE;
        img_q[g] <= tcsi_pkg::RESET_BYTE;
        msk_q[g] <= tcsi_pkg::RESET_BYTE;
      end
      else
      begin
        lat_q[g] <= lat_d;
        img_q[g] <= img_d;
        msk_q[g] <= msk_d;
      end
    end
  end

  // Alarm change tracking and interrupt
  always_comb
  begin
    alm_prev_d = status_one_alarm;
    chg_d      = chg_q;
    if (rd_hit[tcsi_pkg::IDX_SR1])
      chg_d = chg_q & ~msk_q[tcsi_pkg::IDX_SR1][3:0];
    chg_d = chg_d | (status_one_alarm ^ alm_prev_q);
    pend  = (|(lat_q[tcsi_pkg::IDX_SR1] & ~tcsi_pkg::ALARM_BITS & irq_mask_one_q))
          | (|(chg_q & irq_mask_one_q[3:0]))
          | (|(lat_q[tcsi_pkg::IDX_SR2] & irq_mask_two_q))
          | (|(lat_q[tcsi_pkg::IDX_LINK_CHANNEL_STATUS] & link_channel_irq_mask_q));
    int_b_d = ~pend;
  end

  // Control registers, monitors and read data
  always_comb
  begin
    ccr_tx_d = ccr_tx_q;
    ccr_rx_d = ccr_rx_q;
    ccr_rl_d = ccr_rl_q;
    ccr_es_d = ccr_es_q;
    irq_mask_one_d   = irq_mask_one_q;
    irq_mask_two_d   = irq_mask_two_q;
    link_channel_irq_mask_d   = link_channel_irq_mask_q;
    tmon_d   = tmon_q;
    rmon_d   = rmon_q;
    rdata_d  = rdata_q;
    if (cpu_wr)
    begin
      if (cpu_addr == tcsi_pkg::OFS_TX_CRC_AIS_MON)
        ccr_tx_d = cpu_wdata;
      else if (cpu_addr == tcsi_pkg::OFS_RX_CRC_MON)
        ccr_rx_d = cpu_wdata & tcsi_pkg::RX_CTRL_USED;
      else if (cpu_addr == tcsi_pkg::OFS_LINE_RST_LOOP)
        ccr_rl_d = cpu_wdata & tcsi_pkg::RST_LOOP_USED;
      else if (cpu_addr == tcsi_pkg::OFS_ES_CONTROL)
        ccr_es_d = cpu_wdata;
      else if (cpu_addr == tcsi_pkg::OFS_IRQ_MASK_ONE)
        irq_mask_one_d = cpu_wdata;
      else if (cpu_addr == tcsi_pkg::OFS_IRQ_MASK_TWO)
        irq_mask_two_d = cpu_wdata;
      else if (cpu_addr == tcsi_pkg::OFS_LINK_IRQ_MASK)
        link_channel_irq_mask_d = cpu_wdata;
    end
    if (tx_chan_stb && tx_chan_num == ccr_tx_q[4:0])
      tmon_d = tx_chan_data;
    if (rx_chan_stb && rx_chan_num == ccr_rx_q[4:0])
      rmon_d = rx_chan_data;
    if (cpu_rd)
    begin
      if (cpu_addr == tcsi_pkg::OFS_TX_CRC_AIS_MON)
        rdata_d = ccr_tx_q;
      else if (cpu_addr == tcsi_pkg::OFS_RX_CRC_MON)
        rdata_d = ccr_rx_q;
      else if (cpu_addr == tcsi_pkg::OFS_LINE_RST_LOOP)
        rdata_d = ccr_rl_q;
      else if (cpu_addr == tcsi_pkg::OFS_ES_CONTROL)
        rdata_d = ccr_es_q;
      else if (cpu_addr == tcsi_pkg::OFS_IRQ_MASK_ONE)
        rdata_d = irq_mask_one_q;
      else if (cpu_addr == tcsi_pkg::OFS_IRQ_MASK_TWO)
        rdata_d = irq_mask_two_q;
      else if (cpu_addr == tcsi_pkg::OFS_LINK_IRQ_MASK)
        rdata_d = link_channel_irq_mask_q;
      else if (cpu_addr == tcsi_pkg::OFS_TX_MONITOR)
        rdata_d = tmon_q;
      else if (cpu_addr == tcsi_pkg::OFS_RX_MONITOR)
        rdata_d = rmon_q;
      else if (rd_hit[tcsi_pkg::IDX_SR1])
        rdata_d = img_q[tcsi_pkg::IDX_SR1];
      else if (rd_hit[tcsi_pkg::IDX_SR2])
        rdata_d = img_q[tcsi_pkg::IDX_SR2];
      else if (rd_hit[tcsi_pkg::IDX_RX_INFO_REG_ONE])
        rdata_d = img_q[tcsi_pkg::IDX_RX_INFO_REG_ONE];
      else if (rd_hit[tcsi_pkg::IDX_RX_INFO_REG_TWO])
        rdata_d = img_q[tcsi_pkg::IDX_RX_INFO_REG_TWO];
      else if (rd_hit[tcsi_pkg::IDX_RX_INFO_REG_THREE])
        rdata_d = img_q[tcsi_pkg::IDX_RX_INFO_REG_THREE];
      else if (rd_hit[tcsi_pkg::IDX_LINK_CHANNEL_STATUS])
        rdata_d = img_q[tcsi_pkg::IDX_LINK_CHANNEL_STATUS];
      else
        rdata_d = tcsi_pkg::RESET_BYTE;
    end
  end

  // Reset pulses on rising edges of the stored bits only
  always_comb
  begin
    lir_pulse_d = ccr_rl_d[tcsi_pkg::POS_LINE_IF_RST]
                & ~ccr_rl_q[tcsi_pkg::POS_LINE_IF_RST];
    es_pulse_d  = ccr_es_d[tcsi_pkg::POS_ES_RESET]
                & ~ccr_es_q[tcsi_pkg::POS_ES_RESET];
  end

  // Line transmit path; all ones sent as alternating marks
  always_comb
  begin
    ltx_p_d    = ltx_p_q;
    ltx_n_d    = ltx_n_q;
    ais_mark_d = ais_mark_q;
    if (tx_bit_stb)
    begin
      if (ccr_tx_q[tcsi_pkg::POS_ALL_ONES])
      begin
        ltx_p_d    = ~ais_mark_q;
        ltx_n_d    = ais_mark_q;
        ais_mark_d = ~ais_mark_q;
      end
      else if (ccr_rl_q[tcsi_pkg::POS_REMOTE_LOOP])
      begin
        ltx_p_d = line_rx_positive_in;
        ltx_n_d = line_rx_negative_in;
      end
      else
      begin
        ltx_p_d = fmt_tx_pos;
        ltx_n_d = fmt_tx_neg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ccr_tx_q    <= tcsi_pkg::RESET_BYTE;
      ccr_rx_q    <= tcsi_pkg::RESET_BYTE;
      ccr_rl_q    <= tcsi_pkg::RESET_BYTE;
      ccr_es_q    <= tcsi_pkg::RESET_BYTE;
      irq_mask_one_q      <= tcsi_pkg::RESET_BYTE;
      irq_mask_two_q      <= tcsi_pkg::RESET_BYTE;
      link_channel_irq_mask_q      <= tcsi_pkg::RESET_BYTE;
      tmon_q      <= tcsi_pkg::RESET_BYTE;
      rmon_q      <= tcsi_pkg::RESET_BYTE;
      rdata_q     <= tcsi_pkg::RESET_BYTE;
      alm_prev_q  <= 4'h0;
      chg_q       <= 4'h0;
      int_b_q     <= 1'b1;
      ltx_p_q     <= 1'b0;
      ltx_n_q     <= 1'b0;
      ais_mark_q  <= 1'b0;
      lir_pulse_q <= 1'b0;
      es_pulse_q  <= 1'b0;
    end
    else
    begin
      ccr_tx_q    <= ccr_tx_d;
      ccr_rx_q    <= ccr_rx_d;
      ccr_rl_q    <= ccr_rl_d;
      ccr_es_q    <= ccr_es_d;
      irq_mask_one_q      <= irq_mask_one_d;
      irq_mask_two_q      <= irq_mask_two_d;
      link_channel_irq_mask_q      <= link_channel_irq_mask_d;
      tmon_q      <= tmon_d;
      rmon_q      <= rmon_d;
      rdata_q     <= rdata_d;
      alm_prev_q  <= alm_prev_d;
      chg_q       <= chg_d;
      int_b_q     <= int_b_d;
      ltx_p_q     <= ltx_p_d;
      ltx_n_q     <= ltx_n_d;
      ais_mark_q  <= ais_mark_d;
      lir_pulse_q <= lir_pulse_d;
      es_pulse_q  <= es_pulse_d;
    end
  end

  assign cpu_rdata                 = rdata_q;
  assign int_b                     = int_b_q;
  assign line_tx_positive_out      = ltx_p_q;
  assign line_tx_negative_out      = ltx_n_q;
  assign tx_crc_variant_sel        = ccr_tx_q[tcsi_pkg::POS_CRC_VARIANT];
  assign rx_crc_variant_sel        = ccr_rx_q[tcsi_pkg::POS_CRC_VARIANT];
  assign line_if_reset_pulse       = lir_pulse_q;
  assign elastic_store_reset_pulse = es_pulse_q;

endmodule : tcsi_bank

`default_nettype wire

// file: logic/tcsi_pkg.sv
// Purpose: Shared constants for the T1 control, status and interrupt bank
// Assumes: Byte-wide parallel port, one clock domain
// Notes:   Offsets are byte addresses on the control port
`default_nettype none

package tcsi_pkg;

  // Control register offsets
  localparam logic [7:0] OFS_LINE_RST_LOOP  = 8'h0A;
  localparam logic [7:0] OFS_TX_CRC_AIS_MON = 8'h19;
  localparam logic [7:0] OFS_RX_CRC_MON     = 8'h1E;
  localparam logic [7:0] OFS_ES_CONTROL     = 8'h30;

  // Status, information and mask register offsets
  localparam logic [7:0] OFS_STATUS_ONE     = 8'h20;
  localparam logic [7:0] OFS_STATUS_TWO     = 8'h21;
  localparam logic [7:0] OFS_RX_INFO_ONE    = 8'h22;
  localparam logic [7:0] OFS_RX_INFO_TWO    = 8'h31;
  localparam logic [7:0] OFS_RX_INFO_THREE  = 8'h10;
  localparam logic [7:0] OFS_LINK_STATUS    = 8'h32;
  localparam logic [7:0] OFS_IRQ_MASK_ONE   = 8'h23;
  localparam logic [7:0] OFS_IRQ_MASK_TWO   = 8'h24;
  localparam logic [7:0] OFS_LINK_IRQ_MASK  = 8'h33;

  // Channel monitor read registers
  localparam logic [7:0] OFS_TX_MONITOR     = 8'h3A;
  localparam logic [7:0] OFS_RX_MONITOR     = 8'h3B;

  // Field positions
  localparam int unsigned POS_CRC_VARIANT   = 7;
  localparam int unsigned POS_ALL_ONES      = 5;
  localparam int unsigned POS_LINE_IF_RST   = 7;
  localparam int unsigned POS_REMOTE_LOOP   = 6;
  localparam int unsigned POS_ES_RESET      = 6;

  // Writable bits of the control registers, used event bits of receive info three
  localparam logic [7:0] RX_CTRL_USED       = 8'h9F;
  localparam logic [7:0] RST_LOOP_USED      = 8'hC0;
  localparam logic [7:0] RX_INFO_THREE_USED = 8'hF8;

  // Alarm bits of status register one
  localparam logic [7:0] ALARM_BITS         = 8'h0F;

  // Status register indices
  localparam int unsigned NUM_STATUS        = 6;
  localparam int unsigned IDX_SR1           = 0;
  localparam int unsigned IDX_SR2           = 1;
  localparam int unsigned IDX_RX_INFO_REG_ONE          = 2;
  localparam int unsigned IDX_RX_INFO_REG_TWO          = 3;
  localparam int unsigned IDX_RX_INFO_REG_THREE          = 4;
  localparam int unsigned IDX_LINK_CHANNEL_STATUS          = 5;

  // Values after reset
  localparam logic [7:0] RESET_BYTE         = 8'h00;

endpackage : tcsi_pkg

`default_nettype wire

// file: test/tcsi_checker.sv
// Purpose: Port assertions for tcsi_bank
// Assumes: One clock domain, reset active low
// Notes:   Shadows masks and controls from port writes
`default_nettype none
`timescale 1ns/1ps
module tcsi_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Control port
  input wire logic [7:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic       int_b,
  // Sources
  input wire logic [3:0] status_one_alarm,
  input wire logic [7:0] status_two_event,
  input wire logic       tx_bit_stb,
  input wire logic       line_rx_positive_in,
  input wire logic       line_rx_negative_in,
  // Outputs
  input wire logic       line_tx_positive_out,
  input wire logic       line_tx_negative_out,
  input wire logic       tx_crc_variant_sel,
  input wire logic       rx_crc_variant_sel,
  input wire logic       line_if_reset_pulse,
  input wire logic       elastic_store_reset_pulse
);
  logic [7:0] m1_q, m2_q, c19_q, c0a_q, c30_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      {m1_q, m2_q, c19_q, c0a_q, c30_q} <= '0;
    end
    else if (cpu_wr)
    begin
      case (cpu_addr)
        8'h23: m1_q <= cpu_wdata;
        8'h24: m2_q <= cpu_wdata;
        8'h19: c19_q <= cpu_wdata;
        8'h0A: c0a_q <= cpu_wdata;
        8'h30: c30_q <= cpu_wdata;
        default: ;
      endcase
    end
  sequence s_lir_up;
    cpu_wr && cpu_addr == 8'h0A && cpu_wdata[7] && !c0a_q[7];
  endsequence
  sequence s_es_up;
    cpu_wr && cpu_addr == 8'h30 && cpu_wdata[6] && !c30_q[6];
  endsequence
  property p_tcrc;
    cpu_wr && cpu_addr == 8'h19 |=> tx_crc_variant_sel == $past(cpu_wdata[7]);
  endproperty
  property p_rcrc;
    cpu_wr && cpu_addr == 8'h1E |=> rx_crc_variant_sel == $past(cpu_wdata[7]);
  endproperty
  property p_lir;
    s_lir_up |=> line_if_reset_pulse ##1 !line_if_reset_pulse;
  endproperty
  property p_lir_arm;
    line_if_reset_pulse |-> c0a_q[7] && !$past(c0a_q[7]);
  endproperty
  property p_es;
    s_es_up |=> elastic_store_reset_pulse ##1 !elastic_store_reset_pulse;
  endproperty
  property p_ais;
    tx_bit_stb && c19_q[5] |=> line_tx_positive_out != line_tx_negative_out;
  endproperty
  property p_loop;
    tx_bit_stb && !c19_q[5] && c0a_q[6] |=>
      {line_tx_positive_out, line_tx_negative_out} ==
      {$past(line_rx_positive_in), $past(line_rx_negative_in)};
  endproperty
  property p_ev_int;
    |(status_two_event & m2_q) |-> ##2 !int_b;
  endproperty
  property p_alm_int;
    |((status_one_alarm ^ $past(status_one_alarm)) & m1_q[3:0]) |-> ##2 !int_b;
  endproperty
  property p_int_rel;
    $rose(int_b) |-> $past(cpu_rd, 2) || $past(cpu_wr, 2);
  endproperty
  a_tcrc: assert property (p_tcrc)
    else $error("tx crc select mismatch");
  a_rcrc: assert property (p_rcrc)
    else $error("rx crc select mismatch");
  a_lir: assert property (p_lir)
    else $error("line reset pulse missing");
  a_lir_arm: assert property (p_lir_arm)
    else $error("line reset pulse without rising bit");
  a_es: assert property (p_es)
    else $error("store reset pulse missing");
  a_ais: assert property (p_ais)
    else $error("all ones bit not a mark");
  a_loop: assert property (p_loop)
    else $error("remote loop data mismatch");
  a_ev_int: assert property (p_ev_int)
    else $error("event did not interrupt");
  a_alm_int: assert property (p_alm_int)
    else $error("alarm change did not interrupt");
  a_int_rel: assert property (p_int_rel)
    else $error("interrupt released without access");
endmodule : tcsi_checker
`default_nettype wire

// file: test/tcsi_host.sv
// Purpose: Host processor model on the control port
// Assumes: Strobes change at the falling edge
// Notes:   Read data sampled one full cycle after the strobe
`default_nettype none
`timescale 1ns/1ps
module tcsi_host (
  // Clock
  input  wire logic       ref_clk,
  // Control port
  output var  logic [7:0] cpu_addr,
  output var  logic       cpu_wr,
  output var  logic       cpu_rd,
  output var  logic [7:0] cpu_wdata,
  input  wire logic [7:0] cpu_rdata
);
  initial
  begin
    {cpu_addr, cpu_wr, cpu_rd, cpu_wdata} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    {cpu_addr, cpu_wdata, cpu_wr} = {a, v, 1'b1};
    @(negedge ref_clk);
    cpu_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    {cpu_addr, cpu_rd} = {a, 1'b1};
    @(negedge ref_clk);
    cpu_rd = 1'b0;
    @(negedge ref_clk);
    v = cpu_rdata;
  endtask : rd
  // Write-back closes the race with events landing mid-poll
  task automatic poll(input logic [7:0] a, m, output logic [7:0] v);
    wr(a, m);
    rd(a, v);
    wr(a, v & m);
  endtask : poll
  task automatic init;
    logic [7:0] a[7] = '{8'h19, 8'h1E, 8'h0A, 8'h30, 8'h23, 8'h24, 8'h33};
    foreach (a[i])
      wr(a[i], 8'h00);
    wr(8'h30, 8'h40);
  endtask : init
endmodule : tcsi_host
`default_nettype wire

// file: test/test_tcsi_bank.sv
// Purpose: Directed bench for tcsi_bank
// Assumes: Host model drives the control port
// Notes:   Inputs change at the falling edge
`default_nettype none
`timescale 1ns/1ps
module test_tcsi_bank;
  logic       ref_clk, rst_b, cpu_wr, cpu_rd, int_b;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, d, ev2, ri1, tdat, rdat, lnk;
  logic [3:0] alm;
  logic [4:0] tnum, rnum;
  logic       tstb, rstb, bstb, fp, fn, rp, rn, tp, tn, tc, rc, lrp, esp;
  int         fails = 0, n_checks = 0, n_lr = 0, n_es = 0;
  tcsi_host host (.ref_clk, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_rdata);
  tcsi_bank uut (.ref_clk, .rst_b, .cpu_addr, .cpu_wr, .cpu_rd,
    .cpu_wdata, .cpu_rdata, .int_b, .status_one_event(8'h00),
    .status_one_alarm(alm), .status_two_event(ev2),
    .rx_info_one_event(ri1), .rx_info_two_event(8'h00),
    .rx_info_three_event(8'h00), .link_status_event(lnk),
    .tx_chan_stb(tstb), .tx_chan_num(tnum), .tx_chan_data(tdat),
    .rx_chan_stb(rstb), .rx_chan_num(rnum), .rx_chan_data(rdat),
    .tx_bit_stb(bstb), .fmt_tx_pos(fp), .fmt_tx_neg(fn),
    .line_rx_positive_in(rp), .line_rx_negative_in(rn),
    .line_tx_positive_out(tp), .line_tx_negative_out(tn),
    .tx_crc_variant_sel(tc), .rx_crc_variant_sel(rc),
    .line_if_reset_pulse(lrp), .elastic_store_reset_pulse(esp));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    n_lr += int'(lrp === 1'b1);
    n_es += int'(esp === 1'b1);
  end
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // Bounded wait; a hang ends the run
  task automatic wait_int(input logic e);
    for (int i = 0; i < 8 && int_b !== e; i++)
      @(negedge ref_clk);
    chk({7'h00, int_b}, {7'h00, e});
    if (int_b !== e)
      end_sim();
  endtask : wait_int
  task automatic t_ctrl;
    host.wr(8'h19, 8'h80);
    host.wr(8'h1E, 8'hFF);
    chk({6'h00, tc, rc}, 8'h03);
    host.wr(8'h19, 8'h00);
    chk({6'h00, tc, rc}, 8'h01);
    host.rd(8'h1E, d);
    chk(d, 8'h9F);
    host.rd(8'h7F, d);
    chk(d, 8'h00);
  endtask : t_ctrl
  task automatic t_pulse(input logic [7:0] a, v, e);
    int l0 = n_lr;
    int e0 = n_es;
    host.wr(a, 8'h00);
    host.wr(a, v);
    host.wr(a, v);
    host.wr(a, 8'h00);
    host.wr(a, v);
    repeat (3) @(negedge ref_clk);
    chk({4'(n_lr - l0), 4'(n_es - e0)}, e);
    host.wr(a, 8'h00);
  endtask : t_pulse
  task automatic t_mon;
    host.wr(8'h19, 8'h05);
    host.wr(8'h1E, 8'h1F);
    {tstb, tnum, tdat, rstb, rnum, rdat} = {14'h2A55, 14'h3F3C};
    @(negedge ref_clk);
    {tnum, tdat, rnum, rdat} = {13'h055C, 13'h1E99};
    @(negedge ref_clk);
    {tstb, rstb} = 2'b00;
    host.rd(8'h3A, d);
    chk(d, 8'h5C);
    host.rd(8'h3B, d);
    chk(d, 8'h3C);
  endtask : t_mon
  task automatic line_bit;
    @(negedge ref_clk);
    bstb = 1'b1;
    @(negedge ref_clk);
    bstb = 1'b0;
  endtask : line_bit
  task automatic t_line;
    {fp, fn, rp, rn} = 4'b1001;
    host.wr(8'h19, 8'h00);
    line_bit();
    chk({6'h00, tp, tn}, 8'h02);
    host.wr(8'h0A, 8'h40);
    line_bit();
    chk({6'h00, tp, tn}, 8'h01);
    host.wr(8'h19, 8'h20);
    line_bit();
    d[1:0] = {tp, tn};
    line_bit();
    chk({6'h00, d[1:0] ^ {tp, tn}}, 8'h03);
    host.wr(8'h19, 8'h00);
    host.wr(8'h0A, 8'h00);
  endtask : t_line
  task automatic t_stat;
    ri1 = 8'h04;
    @(negedge ref_clk);
    ri1 = 8'h00;
    host.poll(8'h22, 8'h04, d);
    chk(d, 8'h04);
    host.poll(8'h22, 8'h04, d);
    chk(d, 8'h00);
    ri1 = 8'h01;
    @(negedge ref_clk);
    ri1 = 8'h00;
    host.wr(8'h22, 8'h00);
    host.rd(8'h22, d);
    chk(d, 8'h00);
    host.poll(8'h22, 8'h01, d);
    chk(d, 8'h01);
  endtask : t_stat
  task automatic t_irq;
    host.wr(8'h23, 8'h0F);
    host.wr(8'h24, 8'h01);
    alm = 4'h1;
    wait_int(1'b0);
    host.poll(8'h20, 8'h01, d);
    chk(d, 8'h01);
    wait_int(1'b1);
    host.poll(8'h20, 8'h01, d);
    chk(d, 8'h01);
    alm = 4'h0;
    wait_int(1'b0);
    host.poll(8'h20, 8'h01, d);
    wait_int(1'b1);
    ev2 = 8'h01;
    @(negedge ref_clk);
    ev2 = 8'h00;
    wait_int(1'b0);
    host.poll(8'h21, 8'h01, d);
    chk(d, 8'h01);
    wait_int(1'b1);
    host.wr(8'h24, 8'h00);
    ev2 = 8'h02;
    @(negedge ref_clk);
    ev2 = 8'h00;
    repeat (4) @(negedge ref_clk);
    chk({7'h00, int_b}, 8'h01);
    host.wr(8'h33, 8'h01);
    lnk = 8'h01;
    @(negedge ref_clk);
    lnk = 8'h00;
    wait_int(1'b0);
    host.poll(8'h32, 8'h01, d);
    chk(d, 8'h01);
    wait_int(1'b1);
  endtask : t_irq
  initial
  begin
    {alm, ev2, ri1, lnk, tstb, tnum, tdat, rstb, rnum, rdat} = '0;
    {bstb, fp, fn, rp, rn} = '0;
    rst_b = 1'b0;
    // Count rising edges; the clock's first step to 0 is no cycle
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    chk({7'h00, int_b}, 8'h01);
    host.rd(8'h19, d);
    chk(d, 8'h00);
    host.init();
    t_ctrl();
    t_pulse(8'h0A, 8'h80, 8'h20);
    t_pulse(8'h30, 8'h40, 8'h02);
    t_mon();
    t_line();
    t_stat();
    t_irq();
    end_sim();
  end
endmodule : test_tcsi_bank
bind tcsi_bank tcsi_checker u_chk (.ref_clk, .rst_b, .cpu_addr, .cpu_wr,
  .cpu_rd, .cpu_wdata, .int_b, .status_one_alarm, .status_two_event,
  .tx_bit_stb, .line_rx_positive_in, .line_rx_negative_in,
  .line_tx_positive_out, .line_tx_negative_out, .tx_crc_variant_sel,
  .rx_crc_variant_sel, .line_if_reset_pulse, .elastic_store_reset_pulse);
`default_nettype wire
